//--- rtl/trt_pkg.sv
package trt_pkg;
  // Register byte addresses on APB
  localparam logic [7:0] TRT_ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] TRT_ADDR_RELOAD_LO = 8'h04;
  localparam logic [7:0] TRT_ADDR_RELOAD_HI = 8'h08;
  localparam logic [7:0] TRT_ADDR_COUNT_LO  = 8'h0C;
  localparam logic [7:0] TRT_ADDR_COUNT_HI  = 8'h10;
  localparam logic [7:0] TRT_ADDR_CLKCTL    = 8'h14;
  localparam logic [7:0] TRT_ADDR_IRQ_STAT  = 8'h18;
  localparam logic [7:0] TRT_ADDR_IRQ_MASK  = 8'h1C;
  // Control register fields
  localparam int TRT_BIT_HIGH_FLAG  = 7;
  localparam int TRT_BIT_LOW_FLAG   = 6;
  localparam int TRT_BIT_LOW_IE     = 5;
  localparam int TRT_BIT_CAPTURE_EN = 4;
  localparam int TRT_BIT_SPLIT      = 3;
  localparam int TRT_BIT_RUN        = 2;
  localparam int TRT_BIT_EXT_SEL    = 0;
  // Clock control fields
  localparam int TRT_BIT_LOW_CSEL   = 0;
  localparam int TRT_BIT_HIGH_CSEL  = 1;
  // Status fields
  localparam int TRT_ST_HIGH = 0;
  localparam int TRT_ST_LOW  = 1;
  localparam int TRT_ST_CAP  = 2;
  // Writable control bits other than flag bits 7 and 6
  localparam logic [7:0] TRT_CONTROL_WMASK = 8'h3D;
  // Reset values
  localparam logic [7:0] TRT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] TRT_BYTE_RESET    = 8'h00;
  // Prescaler divide
  localparam logic [3:0] TRT_DIV_LAST = 4'hB;
  // Byte extremes
  localparam logic [7:0] TRT_BYTE_MAX = 8'hFF;
  // Clock source choices
  typedef enum logic [1:0] {TRT_SRC_SYS, TRT_SRC_DIV12, TRT_SRC_EXT} trt_src_type;
endpackage : trt_pkg

//--- rtl/trt_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser with registered rise detect
module trt_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      level,
  output logic      rise
);
  logic meta;   // First stage, read only by second
  logic stage2; // Settled level
  logic prev;   // Last level for edge detect
  logic next_rise;

  // Edge compare on settled stages only
  always_comb begin
    next_rise = stage2 & ~prev;
  end

  // Synchroniser chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta   <= 1'b0;
      stage2 <= 1'b0;
      prev   <= 1'b0;
      rise   <= 1'b0;
    end else begin
      meta   <= async_in;
      stage2 <= meta;
      prev   <= stage2;
      rise   <= next_rise;
    end
  end

  assign level = stage2;
endmodule // trt_sync
`default_nettype wire

//--- rtl/trt_timer.sv
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Reload/capture timer with APB registers
module trt_timer
  import trt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_irq_enable,
  input  wire logic        ext_osc_clk,
  input  wire logic        lf_osc_out,
  output logic             irq
);
  // Register state
  logic [7:0] control, next_control;   // Timer control
  logic [7:0] reload_lo, next_reload_lo;
  logic [7:0] reload_hi, next_reload_hi;
  logic [7:0] count_lo, next_count_lo;
  logic [7:0] count_hi, next_count_hi;
  logic [1:0] clkctl, next_clkctl;     // Per-byte clock selects
  logic [2:0] status, next_status;     // Sticky events
  logic [2:0] mask, next_mask;         // Interrupt mask
  logic [3:0] prescale, next_prescale; // Divide-by-12
  logic       div_tick, next_div_tick;
  logic [31:0] next_prdata;
  logic       next_pready;
  logic       next_pslverr;
  logic       next_irq;
  // Synchronised external inputs
  logic       ext_level, ext_rise;
  logic       lf_level, lf_rise;
  logic       ien_level;
  logic       ien_meta;
  // Bus strobes
  logic       wr_en, rd_setup;

  // External oscillator edges counted as ticks
  trt_sync u_ext_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (ext_osc_clk),
    .level    (ext_level),
    .rise     (ext_rise)
  );

  // Low-frequency oscillator edges trigger capture
  trt_sync u_lf_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (lf_osc_out),
    .level    (lf_level),
    .rise     (lf_rise)
  );

  // Pick one byte's tick from its source
  function automatic logic byte_tick(input logic csel, input logic ext_sel,
                                     input logic dtick, input logic etick);
    // Per-byte select overrides to system clock
    if (csel)
      byte_tick = 1'b1;
    else if (ext_sel)
      byte_tick = etick;
    else
      byte_tick = dtick;
  endfunction

  // Register read mux
  function automatic logic [31:0] read_word(input logic [7:0] a, input logic [7:0] c,
                                            input logic [7:0] rl, input logic [7:0] rh,
                                            input logic [7:0] cl, input logic [7:0] ch,
                                            input logic [1:0] k, input logic [2:0] s,
                                            input logic [2:0] m);
    case (a)
      TRT_ADDR_CONTROL:   read_word = {24'h000000, c};
      TRT_ADDR_RELOAD_LO: read_word = {24'h000000, rl};
      TRT_ADDR_RELOAD_HI: read_word = {24'h000000, rh};
      TRT_ADDR_COUNT_LO:  read_word = {24'h000000, cl};
      TRT_ADDR_COUNT_HI:  read_word = {24'h000000, ch};
      TRT_ADDR_CLKCTL:    read_word = {30'h00000000, k};
      TRT_ADDR_IRQ_STAT:  read_word = {29'h00000000, s};
      TRT_ADDR_IRQ_MASK:  read_word = {29'h00000000, m};
      default:            read_word = 32'h00000000;
    endcase
  endfunction

  // Address decode: known addresses accepted
  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      TRT_ADDR_CONTROL, TRT_ADDR_RELOAD_LO, TRT_ADDR_RELOAD_HI,
      TRT_ADDR_COUNT_LO, TRT_ADDR_COUNT_HI, TRT_ADDR_CLKCTL,
      TRT_ADDR_IRQ_STAT, TRT_ADDR_IRQ_MASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  // Level input synchroniser for interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_meta  <= 1'b0;
      ien_level <= 1'b0;
    end else begin
      ien_meta  <= timer_irq_enable;
      ien_level <= ien_meta;
    end
  end

  // Write occurs in access phase; slave answers in one wait cycle
  assign wr_en    = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable;

  // Next-state logic for counters, registers and bus
  always_comb begin
    logic run_hi, run_lo, tick_hi, tick_lo, tick16;
    logic wrap_lo, wrap_hi;
    logic [15:0] cnt16;
    run_hi  = 1'b0;
    run_lo  = 1'b0;
    tick_hi = 1'b0;
    tick_lo = 1'b0;
    tick16  = 1'b0;
    wrap_lo = 1'b0;
    wrap_hi = 1'b0;
    cnt16   = {count_hi, count_lo};
    next_control   = control;
    next_reload_lo = reload_lo;
    next_reload_hi = reload_hi;
    next_count_lo  = count_lo;
    next_count_hi  = count_hi;
    next_clkctl    = clkctl;
    next_status    = status;
    next_mask      = mask;
    // Divide-by-12 prescaler
    if (prescale == TRT_DIV_LAST) begin
      next_prescale = 4'h0;
      next_div_tick = 1'b1;
    end else begin
      next_prescale = prescale + 4'h1;
      next_div_tick = 1'b0;
    end

    tick_lo = byte_tick(clkctl[TRT_BIT_LOW_CSEL], control[TRT_BIT_EXT_SEL], div_tick, ext_rise);
    tick_hi = byte_tick(clkctl[TRT_BIT_HIGH_CSEL], control[TRT_BIT_EXT_SEL], div_tick, ext_rise);

    if (control[TRT_BIT_SPLIT]) begin
      run_hi = control[TRT_BIT_RUN] & tick_hi;
      run_lo = tick_lo;
      if (run_lo) begin
        wrap_lo = (count_lo == TRT_BYTE_MAX);
        next_count_lo = wrap_lo ? reload_lo : count_lo + 8'h01;
      end
      if (run_hi) begin
        wrap_hi = (count_hi == TRT_BYTE_MAX);
        next_count_hi = wrap_hi ? reload_hi : count_hi + 8'h01;
      end
    end else begin
      // 16-bit auto-reload; low-byte select clocks both
      tick16 = control[TRT_BIT_RUN] & tick_lo;
      if (tick16) begin
        wrap_lo = (count_lo == TRT_BYTE_MAX);
        wrap_hi = (cnt16 == 16'hFFFF);
        {next_count_hi, next_count_lo} = wrap_hi ? {reload_hi, reload_lo} : cnt16 + 16'h0001;
      end
    end

    // Software writes; control flags clear by writing zero, status bits by writing one
    if (wr_en) begin
      case (paddr)
        TRT_ADDR_CONTROL:   next_control = (pwdata[7:0] & (TRT_CONTROL_WMASK | 8'hC0));
        TRT_ADDR_RELOAD_LO: next_reload_lo = pwdata[7:0];
        TRT_ADDR_RELOAD_HI: next_reload_hi = pwdata[7:0];
        TRT_ADDR_COUNT_LO:  next_count_lo = pwdata[7:0];
        TRT_ADDR_COUNT_HI:  next_count_hi = pwdata[7:0];
        TRT_ADDR_CLKCTL:    next_clkctl = pwdata[1:0];
        TRT_ADDR_IRQ_STAT:  next_status = status & ~pwdata[2:0];
        TRT_ADDR_IRQ_MASK:  next_mask = pwdata[2:0];
        default:            next_mask = mask;
      endcase
    end

    if (control[TRT_BIT_CAPTURE_EN] && lf_rise) begin
      next_reload_hi = count_hi;
      next_reload_lo = count_lo;
      next_status[TRT_ST_CAP] = 1'b1;
    end
    if (wrap_hi) begin
      next_control[TRT_BIT_HIGH_FLAG] = 1'b1;
      next_status[TRT_ST_HIGH] = 1'b1;
    end
    if (wrap_lo) begin
      next_control[TRT_BIT_LOW_FLAG] = 1'b1;
      next_status[TRT_ST_LOW] = 1'b1;
    end

    next_irq = ien_level & ((next_control[TRT_BIT_HIGH_FLAG] & mask[TRT_ST_HIGH])
             | (next_control[TRT_BIT_LOW_FLAG] & next_control[TRT_BIT_LOW_IE]
                & mask[TRT_ST_LOW])
             | (next_status[TRT_ST_CAP] & mask[TRT_ST_CAP]));

    // One wait state: ready in second access cycle
    next_pready  = psel & penable & ~pready;
    next_pslverr = psel & penable & ~pready & ~addr_ok(paddr);
    next_prdata  = prdata;
    if (rd_setup && !pwrite)
      next_prdata = read_word(paddr, control, reload_lo, reload_hi, count_lo,
                              count_hi, clkctl, status, mask);
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control   <= TRT_CONTROL_RESET;
      reload_lo <= TRT_BYTE_RESET;
      reload_hi <= TRT_BYTE_RESET;
      count_lo  <= TRT_BYTE_RESET;
      count_hi  <= TRT_BYTE_RESET;
      clkctl    <= 2'h0;
      status    <= 3'h0;
      mask      <= 3'h0;
      prescale  <= 4'h0;
      div_tick  <= 1'b0;
      prdata    <= 32'h00000000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      irq       <= 1'b0;
    end else begin
      control   <= next_control;
      reload_lo <= next_reload_lo;
      reload_hi <= next_reload_hi;
      count_lo  <= next_count_lo;
      count_hi  <= next_count_hi;
      clkctl    <= next_clkctl;
      status    <= next_status;
      mask      <= next_mask;
      prescale  <= next_prescale;
      div_tick  <= next_div_tick;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
      irq       <= next_irq;
    end
  end
endmodule // trt_timer
`default_nettype wire

//--- sim/trt_timer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level watch of the timer
module trt_timer_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_irq_enable,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup edge followed by first access edge
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  // One wait state, then the answer
  property p_wait_state;
    s_setup |-> ##1 pready;
  endproperty
  a_wait_state: assert property (p_wait_state) else $error("pready not after one wait");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready held too long");
  property p_in_access;
    pready |-> psel && penable;
  endproperty
  a_in_access: assert property (p_in_access) else $error("pready outside access");
  property p_err_pair;
    pslverr |-> pready;
  endproperty
  a_err_pair: assert property (p_err_pair) else $error("pslverr without pready");
  property p_unmapped;
    pready && paddr > 8'h1C |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_mapped_ok;
    pready && paddr <= 8'h1C && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");
  property p_err_zero;
    pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
  // Sync plus output flop: three cycles of latency
  property p_irq_gate;
    !timer_irq_enable [*4] |-> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
endmodule // trt_timer_assertions
bind trt_timer trt_timer_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_irq_enable(timer_irq_enable), .irq(irq));
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, irq_en, ext, lf;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, irq, er;
  int          error_cnt = 0;
  int          n_checks = 0;
  // Rows: address, write value, read-back value
  logic [7:0] r_a [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h00, 8'h20};
  logic [7:0] r_w [8] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'hFF, 8'hFF, 8'hFD, 8'hFF};
  logic [7:0] r_e [8] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h03, 8'h07, 8'hFD, 8'h00};
  trt_timer i_trt_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_irq_enable(irq_en), .ext_osc_clk(ext), .lf_osc_out(lf),
    .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Bus cycle; waits for pready, never assumes latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, {24'h000000, e})
  endtask
  task results;
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    wt(20000);
    error_cnt++;
    results();
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; irq_en = 1'b1; ext = 1'b0; lf = 1'b0;
    wt(8);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, r_a[i], {24'h000000, r_w[i]});
      rdchk(r_a[i], r_e[i]);
      `CHK(er, r_a[i] == 8'h20)
    end
    // Mid-run reset, then every register back at zero
    presetn <= 1'b0;
    wt(8);
    presetn <= 1'b1;
    for (int a = 0; a < 32; a += 4) rdchk(8'(a), 8'h00);
    // 16-bit wrap FFFF straight to reload value 1200
    apb(1'b1, 8'h14, 32'h1); apb(1'b1, 8'h0C, 32'hFE); apb(1'b1, 8'h10, 32'hFF);
    apb(1'b1, 8'h04, 32'h0); apb(1'b1, 8'h08, 32'h12); apb(1'b1, 8'h1C, 32'h1);
    apb(1'b1, 8'h00, 32'h04);
    wt(8);
    rdchk(8'h00, 8'hC4);
    rdchk(8'h10, 8'h12);
    `CHK(irq, 1'b1)
    irq_en <= 1'b0;
    wt(5);
    `CHK(irq, 1'b0)
    irq_en <= 1'b1;
    wt(5);
    `CHK(irq, 1'b1)
    apb(1'b1, 8'h00, 32'h0); apb(1'b1, 8'h18, 32'h7);
    wt(4);
    `CHK(irq, 1'b0)
    // Split: low byte free-runs, high byte held
    apb(1'b1, 8'h0C, 32'hFE); apb(1'b1, 8'h04, 32'hF0); apb(1'b1, 8'h1C, 32'h2);
    apb(1'b1, 8'h00, 32'h08);
    wt(8);
    rdchk(8'h00, 8'h48);
    rdchk(8'h10, 8'h12);
    `CHK(irq, 1'b0)
    apb(1'b1, 8'h00, 32'h28);
    wt(24);
    `CHK(irq, 1'b1)
    apb(1'b1, 8'h00, 32'h0); apb(1'b1, 8'h18, 32'h7);
    // Capture on oscillator rise, timer stopped
    apb(1'b1, 8'h0C, 32'h34); apb(1'b1, 8'h10, 32'h12); apb(1'b1, 8'h1C, 32'h4);
    apb(1'b1, 8'h00, 32'h10);
    lf <= 1'b1;
    wt(6);
    lf <= 1'b0;
    wt(2);
    rdchk(8'h04, 8'h34);
    rdchk(8'h08, 8'h12);
    rdchk(8'h18, 8'h04);
    `CHK(irq, 1'b1)
    apb(1'b1, 8'h00, 32'h0); apb(1'b1, 8'h18, 32'h7);
    // External source: idle oscillator means no count
    apb(1'b1, 8'h14, 32'h0); apb(1'b1, 8'h0C, 32'hFE); apb(1'b1, 8'h10, 32'hFF);
    apb(1'b1, 8'h00, 32'h05);
    wt(20);
    rdchk(8'h00, 8'h05);
    repeat (4) begin
      ext <= 1'b1;
      wt(4);
      ext <= 1'b0;
      wt(4);
    end
    rdchk(8'h00, 8'hC5);
    results();
  end
endmodule // testbench
`default_nettype wire
